// [verilog/cte_pkg.sv]
// Package for the timer event-control block: register map, field layout,
// reset values and action encodings.
// Assumes a 32-bit APB slave with one register per aligned word.
package cte_pkg;

  // Register byte offsets
  localparam logic [7:0] CTE_OFS_CTRL = 8'h00;
  localparam logic [7:0] CTE_OFS_EVCTL = 8'h20;
  localparam logic [7:0] CTE_OFS_STATUS = 8'h30;
  localparam logic [7:0] CTE_OFS_MASK = 8'h34;

  // Reset values
  localparam logic [31:0] CTE_EVCTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTE_CTRL_RESET = 32'h0000_0000;
  localparam logic [8:0] CTE_IRQ_RESET = 9'h000;

  // Writable bits of the event routing control register
  localparam logic [31:0] CTE_EVCTL_MASK = 32'h0F0F_F7FF;

  // Field positions in the event routing control register
  localparam int CTE_CH_OUT_LSB = 24;
  localparam int CTE_CH_IN_LSB = 16;
  localparam int CTE_IN_EN_LSB = 14;
  localparam int CTE_IN_INV_LSB = 12;
  localparam int CTE_CYCLE_EO_BIT = 10;
  localparam int CTE_RETRIG_EO_BIT = 9;
  localparam int CTE_WRAP_EO_BIT = 8;
  localparam int CTE_CYCLE_SEL_LSB = 6;
  localparam int CTE_ACT1_LSB = 3;
  localparam int CTE_ACT0_LSB = 0;

  // Control register field
  localparam int CTE_CTRL_ENABLE_BIT = 0;

  // Interrupt status and mask layout
  localparam int CTE_IRQ_WRAP_BIT = 0;
  localparam int CTE_IRQ_RETRIG_BIT = 1;
  localparam int CTE_IRQ_CYCLE_BIT = 2;
  localparam int CTE_IRQ_FAULT_BIT = 3;
  localparam int CTE_IRQ_CH_LSB = 4;
  localparam int CTE_IRQ_WIDTH = 9;

  // Channel and input counts
  localparam int CTE_NUM_CH = 4;
  localparam int CTE_NUM_IN = 2;

  // Counter-cycle position select
  typedef enum logic [1:0] {
    CTE_CYC_BEGIN = 2'h0,
    CTE_CYC_END = 2'h1,
    CTE_CYC_BETWEEN = 2'h2,
    CTE_CYC_BOUNDARY = 2'h3
  } cte_cycle_sel_type;

  // Input actions, shared codes and per-input meanings
  localparam logic [2:0] CTE_ACT_OFF = 3'h0;
  localparam logic [2:0] CTE_ACT_RETRIG = 3'h1;
  localparam logic [2:0] CTE_ACT_A_EACH = 3'h2;
  localparam logic [2:0] CTE_ACT_A_START = 3'h3;
  localparam logic [2:0] CTE_ACT_A_INC = 3'h4;
  localparam logic [2:0] CTE_ACT_A_COUNT = 3'h5;
  localparam logic [2:0] CTE_ACT_B_DIR = 3'h2;
  localparam logic [2:0] CTE_ACT_B_STOP = 3'h3;
  localparam logic [2:0] CTE_ACT_B_DEC = 3'h4;
  localparam logic [2:0] CTE_ACT_B_PER_WID = 3'h5;
  localparam logic [2:0] CTE_ACT_B_WID_PER = 3'h6;
  localparam logic [2:0] CTE_ACT_FAULT = 3'h7;

endpackage

// [verilog/cte_input_cond.sv]
// One timer event input: enable gate, polarity invert and edge detection.
// Assumes the event line is driven by logic on the same clock.
`timescale 1ns/1ps
module cte_input_cond
  import cte_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic event_in,
  input wire logic enable,
  input wire logic invert,
  output logic level,
  output logic rise,
  output logic fall
);

  logic prev_reg;

  // Polarity applied before any use, then gated by the enable
  assign level = enable & (event_in ^ invert);

  // Previous level for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= 1'b0;
    else
      prev_reg <= level;
  end

  // Edges only while enabled, so a disabled input yields nothing
  assign rise = level & ~prev_reg;
  assign fall = enable & ~level & prev_reg;

endmodule

// [verilog/cte_event_control.sv]
// Event control of a control timer: routes counter events out, gates
// event inputs in and decodes input actions for the counter core.
// Assumes an APB master on clk and a counter core on the same clock
// supplying one-cycle condition pulses.
`timescale 1ns/1ps
module cte_event_control
  import cte_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic peripheral_write_guard,
  input wire logic [3:0] channel_match,
  input wire logic [3:0] channel_event_in,
  input wire logic cycle_begin,
  input wire logic cycle_first,
  input wire logic cycle_end,
  input wire logic counter_retrig,
  input wire logic counter_wrap,
  input wire logic timer_event_input_a,
  input wire logic timer_event_input_b,
  output logic [3:0] channel_event_out,
  output logic cycle_event_out,
  output logic retrig_event_out,
  output logic wrap_event_out,
  output logic [3:0] capture_request,
  output logic timer_enable,
  output logic act_retrigger,
  output logic act_start,
  output logic act_stop,
  output logic act_count,
  output logic act_increment,
  output logic act_decrement,
  output logic count_gate,
  output logic dir_down,
  output logic fault_nonrec,
  output logic irq
);

  logic [31:0] evctl_reg;
  logic [31:0] ctrl_reg;
  logic [8:0] status_reg;
  logic [8:0] status_next;
  logic [8:0] mask_reg;
  logic [8:0] mask_next;
  logic [31:0] prdata_reg;
  logic ready_reg;
  logic err_reg;
  logic access;
  logic commit;
  logic hit_ctrl;
  logic hit_evctl;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic [31:0] read_value;
  logic [8:0] irq_events;

  // Fields of the event routing control register
  logic [3:0] channel_event_out_enable;
  logic [3:0] channel_event_in_enable;
  logic [1:0] timer_input_enable;
  logic [1:0] timer_input_invert;
  logic cycle_event_out_enable;
  logic retrig_event_out_enable;
  logic wrap_event_out_enable;
  cte_cycle_sel_type cycle_position_select;
  logic [2:0] input1_action;
  logic [2:0] input0_action;

  // Conditioned timer inputs
  logic [1:0] raw_in;
  logic [1:0] in_level;
  logic [1:0] in_rise;
  logic [1:0] in_fall;
  logic cycle_hit;
  logic a_rise;
  logic b_rise;
  logic b_fall;
  logic [3:0] meas_capture;

  // Field extraction; bits outside the writable mask never reach these,
  // so reserved positions always read back as zero
  assign channel_event_out_enable = evctl_reg[CTE_CH_OUT_LSB +: 4];
  assign channel_event_in_enable = evctl_reg[CTE_CH_IN_LSB +: 4];
  assign timer_input_enable = evctl_reg[CTE_IN_EN_LSB +: 2];
  assign timer_input_invert = evctl_reg[CTE_IN_INV_LSB +: 2];
  assign cycle_event_out_enable = evctl_reg[CTE_CYCLE_EO_BIT];
  assign retrig_event_out_enable = evctl_reg[CTE_RETRIG_EO_BIT];
  assign wrap_event_out_enable = evctl_reg[CTE_WRAP_EO_BIT];
  assign cycle_position_select = cte_cycle_sel_type'(evctl_reg[CTE_CYCLE_SEL_LSB +: 2]);
  assign input1_action = evctl_reg[CTE_ACT1_LSB +: 3];
  assign input0_action = evctl_reg[CTE_ACT0_LSB +: 3];
  assign timer_enable = ctrl_reg[CTE_CTRL_ENABLE_BIT];

  // APB address decode
  assign hit_ctrl = (paddr == CTE_OFS_CTRL);
  assign hit_evctl = (paddr == CTE_OFS_EVCTL);
  assign hit_status = (paddr == CTE_OFS_STATUS);
  assign hit_mask = (paddr == CTE_OFS_MASK);
  assign mapped = hit_ctrl | hit_evctl | hit_status | hit_mask;

  // Access phase waits one cycle; commit is the edge with pready high
  assign access = psel & penable;
  assign commit = access & ready_reg;
  assign pready = ready_reg;
  assign pslverr = ready_reg & err_reg;
  assign prdata = prdata_reg;

  // Read multiplexer, reserved bits read as zero
  always_comb
  begin
    read_value = 32'h0000_0000;
    if (hit_ctrl)
      read_value = ctrl_reg;
    else if (hit_evctl)
      read_value = evctl_reg;
    else if (hit_status)
      read_value = {23'h000000, status_reg};
    else if (hit_mask)
      read_value = {23'h000000, mask_reg};
  end

  // Wait state and registered read data; read data is captured in the
  // first access cycle, so it holds still while pready stands
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else if (access && !ready_reg)
    begin
      ready_reg <= 1'b1;
      err_reg <= ~mapped;
      prdata_reg <= pwrite ? 32'h0000_0000 : read_value;
    end
    else
    begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end
  end

  // Control register holds the timer enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= CTE_CTRL_RESET;
    else if (commit && pwrite && hit_ctrl)
      ctrl_reg <= {31'h00000000, pwdata[CTE_CTRL_ENABLE_BIT]};
  end

  // Event control only changes with timer off and no write guard;
  // a refused write is silent and answers without an error
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evctl_reg <= CTE_EVCTL_RESET;
    else if (commit && pwrite && hit_evctl && !timer_enable && !peripheral_write_guard)
      evctl_reg <= pwdata & CTE_EVCTL_MASK;
  end

  // Mask next value, shared by the mask and the interrupt output
  always_comb
  begin
    mask_next = mask_reg;
    if (commit && pwrite && hit_mask)
      mask_next = pwdata[CTE_IRQ_WIDTH-1:0];
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_reg <= CTE_IRQ_RESET;
    else
      mask_reg <= mask_next;
  end

  // Both timer inputs packed into one vector, one conditioner instance each
  assign raw_in = {timer_event_input_b, timer_event_input_a};

  // One conditioner per timer input, index 0 is input a
  genvar gi;
  generate
    for (gi = 0; gi < CTE_NUM_IN; gi = gi + 1)
    begin : g_in
      cte_input_cond u_cond (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(raw_in[gi]),
        .enable(timer_input_enable[gi]),
        .invert(timer_input_invert[gi]),
        .level(in_level[gi]),
        .rise(in_rise[gi]),
        .fall(in_fall[gi])
      );
    end
  endgenerate

  // Edge taps for the action decoders
  assign a_rise = in_rise[0];
  assign b_rise = in_rise[1];
  assign b_fall = in_fall[1];

  // Channel events out and gated capture events in
  assign channel_event_out = channel_match & channel_event_out_enable;

  // Period and width measurement on input b
  always_comb
  begin
    meas_capture = 4'h0;
    if (input1_action == CTE_ACT_B_PER_WID)
    begin
      meas_capture[0] = b_rise;
      meas_capture[1] = b_fall;
    end
    else if (input1_action == CTE_ACT_B_WID_PER)
    begin
      meas_capture[1] = b_rise;
      meas_capture[0] = b_fall;
    end
  end

  // Enabled incoming events plus measurement captures
  assign capture_request = (channel_event_in & channel_event_in_enable) | meas_capture;

  // Cycle position choice for the counter cycle event
  always_comb
  begin
    case (cycle_position_select)
      CTE_CYC_BEGIN: cycle_hit = cycle_begin;
      CTE_CYC_END: cycle_hit = cycle_end;
      CTE_CYC_BETWEEN: cycle_hit = cycle_begin & ~cycle_first;
      CTE_CYC_BOUNDARY: cycle_hit = (cycle_begin & cycle_first) | cycle_end;
      default: cycle_hit = 1'b0;
    endcase
  end

  // Counter events out, same cycle as their cause
  assign cycle_event_out = cycle_hit & cycle_event_out_enable;
  assign retrig_event_out = counter_retrig & retrig_event_out_enable;
  assign wrap_event_out = counter_wrap & wrap_event_out_enable;

  // Input a actions; code 6 is reserved and decodes to nothing
  always_comb
  begin
    act_count = 1'b0;
    act_increment = 1'b0;
    act_start = 1'b0;
    count_gate = 1'b0;
    case (input0_action)
      CTE_ACT_A_EACH: act_count = a_rise;
      CTE_ACT_A_START: act_start = a_rise;
      CTE_ACT_A_INC: act_increment = a_rise;
      CTE_ACT_A_COUNT: count_gate = in_level[0];
      default: count_gate = 1'b0;
    endcase
  end

  // Input b actions
  always_comb
  begin
    act_stop = 1'b0;
    act_decrement = 1'b0;
    dir_down = 1'b0;
    case (input1_action)
      CTE_ACT_B_DIR: dir_down = in_level[1];
      CTE_ACT_B_STOP: act_stop = b_rise;
      CTE_ACT_B_DEC: act_decrement = b_rise;
      default: dir_down = 1'b0;
    endcase
  end

  // Actions shared by both inputs
  assign act_retrigger = ((input0_action == CTE_ACT_RETRIG) & a_rise) |
                         ((input1_action == CTE_ACT_RETRIG) & b_rise);
  assign fault_nonrec = ((input0_action == CTE_ACT_FAULT) & a_rise) |
                        ((input1_action == CTE_ACT_FAULT) & b_rise);

  // Sticky events; the counter cycle bit follows the position select,
  // the top status bit is spare and stays clear
  assign irq_events = {1'b0,
                       channel_match,
                       fault_nonrec,
                       cycle_hit,
                       counter_retrig,
                       counter_wrap};

  // Read of status clears only the bits it returned; an event landing in
  // the wait state or in the commit cycle stays set for the next read
  always_comb
  begin
    status_next = status_reg;
    if (commit && !pwrite && hit_status)
      status_next = status_reg & ~prdata_reg[CTE_IRQ_WIDTH-1:0];
    status_next = status_next | irq_events;
  end

  // Status register takes its next value every cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= CTE_IRQ_RESET;
    else
      status_reg <= status_next;
  end

  // Level interrupt from unmasked status, in step with a mask write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_next);
  end

endmodule

// [sim/cte_event_control_checker.sv]
// Checker for the event-control block: output events and APB answer timing.
// Assumes it is bound onto cte_event_control, one clock domain.
`timescale 1ns/1ps
module cte_event_control_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] channel_match,
  input wire logic [3:0] channel_event_in,
  input wire logic [3:0] channel_event_out,
  input wire logic [3:0] capture_request,
  input wire logic cycle_begin,
  input wire logic cycle_end,
  input wire logic cycle_event_out,
  input wire logic counter_retrig,
  input wire logic retrig_event_out,
  input wire logic counter_wrap,
  input wire logic wrap_event_out
);
  // One clock and one reset for all checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Output events only with their cause
  ch_out_cause_a: assert property ((channel_event_out & ~channel_match) == 4'h0)
    else $error("channel event without match");
  cap_in_cause_a: assert property ((capture_request[3:2] & ~channel_event_in[3:2]) == 2'h0)
    else $error("capture without incoming event");
  cycle_cause_a: assert property (cycle_event_out |-> (cycle_begin || cycle_end))
    else $error("cycle event without cycle position");
  retrig_cause_a: assert property (retrig_event_out |-> counter_retrig)
    else $error("retrigger event without retrigger");
  wrap_cause_a: assert property (wrap_event_out |-> counter_wrap)
    else $error("wrap event without wrap");
  wrap_pulse_a: assert property ($rose(wrap_event_out) |-> $rose(counter_wrap))
    else $error("wrap event not in cycle of cause");
  // Register bus answer
  ready_wait_a: assert property (psel && penable && !pready |-> ##1 pready)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside an answer");
  cover property (pslverr);
  cover property (wrap_event_out);
  cover property (cycle_event_out && cycle_begin);
  cover property (capture_request[1:0] != 2'h0);
endmodule

bind cte_event_control cte_event_control_checker chk (.clk, .rst_n, .psel, .penable,
  .pready, .pslverr, .channel_match, .channel_event_in, .channel_event_out,
  .capture_request, .cycle_begin, .cycle_end, .cycle_event_out, .counter_retrig,
  .retrig_event_out, .counter_wrap, .wrap_event_out);

// [sim/cte_router_model.sv]
// Event routing side: counter pulses, channel events and input lines.
// Assumes the bench calls drive once a cycle to set the next pattern.
`timescale 1ns/1ps
module cte_router_model (
  input wire logic clk,
  output logic [14:0] ev
);
  // Quiet from time zero
  initial ev = 15'h0000;
  // Input lines are same-clock levels with no fault filter
  task automatic drive(input logic [14:0] v);
    @(posedge clk);
    ev <= v;
    #1;
  endtask
endmodule

// [sim/control_timer_event_control_bench.sv]
// Bench for the event-control block: registers, interrupt and random events.
// Assumes cte_pkg, the router model and the checker are compiled first.
`timescale 1ns/1ps
module control_timer_event_control_bench import cte_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic guard = 1'b0, pready, pslverr, err, timer_enable, irq, cyc, ret, wr, pa, pb;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, cfg, lf = 32'h40BA09F3;
  logic [3:0] cho, cap;
  logic [14:0] ev;
  logic [8:0] act, st;
  int fail_count = 0, checked = 0;
  // Clock and instances
  always #12.5 clk = ~clk;
  cte_router_model m (.clk(clk), .ev(ev));
  cte_event_control dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .peripheral_write_guard(guard), .channel_match(ev[3:0]),
    .channel_event_in(ev[7:4]), .cycle_begin(ev[11]), .cycle_first(ev[12]),
    .cycle_end(ev[10]), .counter_retrig(ev[9]), .counter_wrap(ev[8]),
    .timer_event_input_a(ev[14]), .timer_event_input_b(ev[13]), .channel_event_out(cho),
    .cycle_event_out(cyc), .retrig_event_out(ret), .wrap_event_out(wr),
    .capture_request(cap), .timer_enable(timer_enable), .act_retrigger(act[8]),
    .act_start(act[7]), .act_stop(act[6]), .act_count(act[5]), .act_increment(act[4]),
    .act_decrement(act[3]), .count_gate(act[2]), .dir_down(act[1]),
    .fault_nonrec(act[0]), .irq(irq));
  // Verdict and comparisons
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t reg %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_ev(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t events %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // One APB transfer; pready and read data are taken at the same rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One event cycle against the integer model
  task automatic step(input logic [14:0] v);
    logic la, lb, ra, rb, fb, hit;
    logic [3:0] mc;
    logic [2:0] a0, a1;
    logic [19:0] e;
    la = (v[14] ^ cfg[12]) & cfg[14];
    lb = (v[13] ^ cfg[13]) & cfg[15];
    ra = la & !pa;
    rb = lb & !pb;
    fb = !lb & pb;
    a0 = cfg[2:0];
    a1 = cfg[5:3];
    case (cfg[7:6])
      2'h0: hit = v[11];
      2'h1: hit = v[10];
      2'h2: hit = v[11] & !v[12];
      default: hit = (v[11] & v[12]) | v[10];
    endcase
    mc = v[7:4] & cfg[19:16];
    if (a1 == CTE_ACT_B_PER_WID)
      mc = mc | {2'h0, fb, rb};
    if (a1 == CTE_ACT_B_WID_PER)
      mc = mc | {2'h0, rb, fb};
    e = {v[3:0] & cfg[27:24], mc, cfg[10] & hit, v[9] & cfg[9], v[8] & cfg[8],
      (a0 == CTE_ACT_RETRIG & ra) | (a1 == CTE_ACT_RETRIG & rb), a0 == CTE_ACT_A_START & ra,
      a1 == CTE_ACT_B_STOP & rb, a0 == CTE_ACT_A_EACH & ra, a0 == CTE_ACT_A_INC & ra,
      a1 == CTE_ACT_B_DEC & rb, a0 == CTE_ACT_A_COUNT & la, a1 == CTE_ACT_B_DIR & lb,
      (a0 == CTE_ACT_FAULT & ra) | (a1 == CTE_ACT_FAULT & rb)};
    st = st | {1'b0, v[3:0], e[0], hit, v[9], v[8]};
    m.drive(v);
    cmp_ev({cho, cap, cyc, ret, wr, act}, e);
    pa = la;
    pb = lb;
  endtask
  // Main sequence
  initial
  begin
    cfg = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, CTE_OFS_EVCTL, 32'h0);
    cmp_reg(rd, CTE_EVCTL_RESET);
    apb(1'b0, 8'h3C, 32'h0);
    cmp_reg({rd[30:0], err}, 32'h1);
    apb(1'b1, CTE_OFS_MASK, 32'h1);
    m.drive(15'h0100);
    m.drive(15'h0000);
    cmp_reg({31'h0, irq}, 32'h1);
    apb(1'b0, CTE_OFS_STATUS, 32'h0);
    #1;
    cmp_reg(rd, 32'h1);
    cmp_reg({31'h0, irq}, 32'h0);
    apb(1'b1, CTE_OFS_MASK, 32'h0);
    m.drive(15'h0100);
    m.drive(15'h0000);
    cmp_reg({31'h0, irq}, 32'h0);
    apb(1'b0, CTE_OFS_STATUS, 32'h0);
    cmp_reg(rd, 32'h1);
    apb(1'b1, CTE_OFS_CTRL, 32'h1);
    #1;
    cmp_reg({31'h0, timer_enable}, 32'h1);
    apb(1'b1, CTE_OFS_EVCTL, 32'hFFFF_FFFF);
    apb(1'b1, CTE_OFS_CTRL, 32'h0);
    guard <= 1'b1;
    apb(1'b1, CTE_OFS_EVCTL, 32'hFFFF_FFFF);
    guard <= 1'b0;
    apb(1'b0, CTE_OFS_EVCTL, 32'h0);
    cmp_reg(rd, 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      lf = lfsr(lf);
      cfg = (lf & CTE_EVCTL_MASK & 32'hFFFF_FF00) | {24'h0, i[1:0], i[2:0], i[4:2]};
      apb(1'b1, CTE_OFS_EVCTL, cfg);
      apb(1'b0, CTE_OFS_EVCTL, 32'h0);
      cmp_reg(rd, cfg);
      apb(1'b0, CTE_OFS_STATUS, 32'h0);
      st = 9'h000;
      pa = (ev[14] ^ cfg[12]) & cfg[14];
      pb = (ev[13] ^ cfg[13]) & cfg[15];
      for (int j = 0; j < 8; j++)
      begin
        lf = lfsr(lf);
        step(lf[14:0]);
        step(lf[14:0] & 15'h6000);
      end
      apb(1'b0, CTE_OFS_STATUS, 32'h0);
      cmp_reg(rd, {23'h000000, st});
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, CTE_OFS_EVCTL, 32'h0);
    cmp_reg(rd, CTE_EVCTL_RESET);
    tally_and_finish;
  end
  // Watchdog
  initial
  begin
    #500000;
    fail_count++;
    tally_and_finish;
  end
endmodule
